/* File: logic/radio_regs.svh */
`ifndef RADIO_REGS_SVH
`define RADIO_REGS_SVH
`define START_PATTERN    16'hE2E2
`define START_SYMBOL     8'hE2
`define LINK_CLK_HZ      31_250_000
`define SLOW_BPS         4_800
`define FAST_BPS         19_200
`define REF_PERIOD_NS    100
`define CFG_HALF_NS      800
`define CFG_HALF_CYCLES  ((`CFG_HALF_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define REARM_LOW_NS     1_000
`define REARM_LOW_CYCLES ((`REARM_LOW_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define CFG_BYTE_BITS    8
`define CFG_READ_BIT     7
`endif

/* File: logic/radio_pkg.sv */
package radio_pkg;
  // Operating mode presented to the analog section
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'h0,
    MODE_RX    = 2'h1,
    MODE_TX    = 2'h2
  } op_mode_t;
  // Modulation type
  typedef enum logic {
    KEY_ASK = 1'h0,
    KEY_OOK = 1'h1
  } keying_t;
  // Host configuration sequencer
  typedef enum logic [1:0] {
    CFG_IDLE = 2'h0,
    CFG_LOW  = 2'h1,
    CFG_HIGH = 2'h2,
    CFG_END  = 2'h3
  } cfg_state_t;
endpackage : radio_pkg

/* File: logic/radio_link_if.sv */
`timescale 1ns/1ps
interface radio_link_if;
  logic tx_rx_select;         // Host: transmit/receive
  logic keying_select;        // Host: KEYING_SELECT
  logic sleep_select;         // Host: sleep
  logic start_pattern_enable; // Host: start pattern recognition
  logic receive_rate_select;  // Host: 4.8k/19.2k
  logic enhanced_mode_wake;   // Host: wakes enhanced control
  logic unused_a;             // Host: held low
  logic unused_b;             // Host: held low
  logic config_select;        // Host: config port select
  logic config_serial_clock;  // Host: config clock, or mode bit0
  logic host_data_o;          // Host data drive value
  logic host_data_oe;         // Host data enable
  logic dev_data_o;           // Device data drive value
  logic dev_data_oe;          // Device data enable
  logic config_serial_data;   // Resolved data line
  logic recovered_bit_clock;  // Device: recovered clock
  logic receive_data_out;     // Device: receive data
  // Undriven line reads low, as if pulled down
  assign config_serial_data = dev_data_oe ? dev_data_o : (host_data_oe & host_data_o);
  modport device (
    input  tx_rx_select, keying_select, sleep_select, start_pattern_enable,
    input  receive_rate_select, enhanced_mode_wake, unused_a, unused_b,
    input  config_select, config_serial_clock, config_serial_data,
    output dev_data_o, dev_data_oe, recovered_bit_clock, receive_data_out
  );
  modport host (
    output tx_rx_select, keying_select, sleep_select, start_pattern_enable,
    output receive_rate_select, enhanced_mode_wake, unused_a, unused_b,
    output config_select, config_serial_clock, host_data_o, host_data_oe,
    input  config_serial_data, recovered_bit_clock, receive_data_out
  );
endinterface : radio_link_if

/* File: logic/radio_device.sv */
`timescale 1ns/1ps
`include "radio_regs.svh"
module radio_device #(
  parameter int unsigned SLOW_BIT_CYCLES = `LINK_CLK_HZ / `SLOW_BPS,
  parameter int unsigned FAST_BIT_CYCLES = `LINK_CLK_HZ / `FAST_BPS
) (
  // Clock and reset
  input  wire logic              link_clk,
  input  wire logic              rst,
  // Straps and analog-side inputs
  input  wire logic              powerup_mode_jumper,
  input  wire logic              recovery_enable,
  input  wire logic              slicer_data,
  // Decoded controls
  output radio_pkg::op_mode_t    op_mode,
  output radio_pkg::keying_t     keying,
  output logic                   slow_rate,
  output logic                   enhanced_active,
  output logic [7:0]             control_byte,
  output logic                   control_byte_strobe,
  // Link to the host
  radio_link_if.device           link
);
  import radio_pkg::*;

  localparam logic [15:0] SLOW_P = 16'(SLOW_BIT_CYCLES);
  localparam logic [15:0] FAST_P = 16'(FAST_BIT_CYCLES);

  logic [11:0] pin_s1;         // First sync stage, read only by pin_s2
  logic [11:0] pin_s2;         // Synchronised pins
  logic        cclk_prev;      // Config clock, one cycle older
  logic        start_pattern_enable_prev;      // Start enable, one cycle older
  logic [1:0]  strap_cnt;      // Waits out the strap synchroniser
  logic        strap_taken;    // Strap has been captured
  logic        jumper_enh;     // Enhanced mode chosen at power-up
  logic        woke;           // Wake input seen high
  logic [15:0] bit_cnt;        // Position within a bit period
  logic [15:0] period;         // Current bit period
  logic [15:0] rx_shift;       // Received bits, newest in bit 0
  logic        clk_active;     // Recovered clock running
  logic [2:0]  cfg_bits;       // Bits of the current byte
  logic [7:0]  cfg_asm;        // Assembly register
  logic [7:0]  rd_shift;       // Read-back shifter
  logic        first_byte;     // Next byte is the command byte
  logic        reading;        // Read phase of a transfer
  logic        cclk_rise;
  logic        start_pattern_enable_rise;
  logic        cfg_on;
  logic        sample_now;
  logic [15:0] next_shift;

  // Named views of the synchronised pins
  wire s_slicer = pin_s2[0];
  wire s_cdat   = pin_s2[1];
  wire s_cclk   = pin_s2[2];
  wire s_sel    = pin_s2[3];
  wire s_txrx   = pin_s2[4];
  wire s_key    = pin_s2[5];
  wire s_sleep  = pin_s2[6];
  wire s_rate   = pin_s2[7];
  wire s_start_pattern_enable   = pin_s2[8];
  wire s_wake   = pin_s2[9];
  wire s_rec    = pin_s2[10];
  wire s_jump   = pin_s2[11];

  // Two-flop synchronisers for every host pin except unused_a and unused_b
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= 12'h000;
      pin_s2 <= 12'h000;
    end
    else
    begin
      pin_s1 <= {powerup_mode_jumper, recovery_enable,
                 link.enhanced_mode_wake, link.start_pattern_enable,
                 link.receive_rate_select, link.sleep_select, link.keying_select,
                 link.tx_rx_select, link.config_select, link.config_serial_clock,
                 link.config_serial_data, slicer_data};
      pin_s2 <= pin_s1;
    end
  end

  // Edge history taken from the second stage only
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      cclk_prev <= 1'b0;
      start_pattern_enable_prev <= 1'b0;
    end
    else
    begin
      cclk_prev <= s_cclk;
      start_pattern_enable_prev <= s_start_pattern_enable;
    end
  end

  assign cclk_rise = s_cclk & ~cclk_prev;
  assign start_pattern_enable_rise = s_start_pattern_enable & ~start_pattern_enable_prev;

  // Strap is caught after reset once the synchroniser has settled
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_cnt   <= 2'h0;
      strap_taken <= 1'b0;
      jumper_enh  <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h3)
      begin
        strap_taken <= 1'b1;
        jumper_enh  <= pin_s2[3] | s_jump;
      end
    end
  end

  // Enhanced control stays asleep until the host wakes it
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      woke <= 1'b0;
    else if (strap_taken && jumper_enh && s_wake)
      woke <= 1'b1;
  end

  assign enhanced_active = woke;

  // Mode decode; legacy reuses the config pins as plain inputs
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      op_mode   <= MODE_SLEEP;
      keying    <= KEY_ASK;
      slow_rate <= 1'b1;
    end
    else if (woke)
    begin
      if (s_sleep)
        op_mode <= MODE_SLEEP;
      else
        op_mode <= s_txrx ? MODE_TX : MODE_RX;
      keying    <= s_key ? KEY_OOK : KEY_ASK;
      slow_rate <= s_rate;
    end
    else if (strap_taken && !jumper_enh)
    begin
      // Clock pin is bit 0, data pin is bit 1
      unique case ({s_cdat, s_cclk})
        2'h0: op_mode <= MODE_SLEEP;
        2'h1: op_mode <= MODE_TX;
        2'h2: op_mode <= MODE_TX;
        2'h3: op_mode <= MODE_RX;
      endcase
      keying    <= s_cdat ? KEY_ASK : KEY_OOK;
      slow_rate <= 1'b1;
    end
  end

  // Bit timing follows the selected receive rate
  assign period     = slow_rate ? SLOW_P : FAST_P;
  assign sample_now = (bit_cnt == (period >> 1));
  assign next_shift = {rx_shift[14:0], s_slicer};

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      bit_cnt <= 16'h0000;
    else if (bit_cnt >= period - 16'h0001)
      bit_cnt <= 16'h0000;
    else
      bit_cnt <= bit_cnt + 16'h0001;
  end

  // Start detection; re-arming clears both history and clock
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_shift   <= 16'h0000;
      clk_active <= 1'b0;
    end
    else if (start_pattern_enable_rise || !s_rec)
    begin
      rx_shift   <= 16'h0000;
      clk_active <= 1'b0;
    end
    else if (sample_now)
    begin
      rx_shift <= next_shift;
      // Enabled start pattern replaces the plain start symbol
      if (s_start_pattern_enable && next_shift == `START_PATTERN)
        clk_active <= 1'b1;
      else if (!s_start_pattern_enable && next_shift[7:0] == `START_SYMBOL)
        clk_active <= 1'b1;
    end
  end

  // Recovered clock: rises with each mid-bit sample, falls at the bit's end
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      link.recovered_bit_clock <= 1'b0;
      link.receive_data_out    <= 1'b0;
    end
    else if (!s_rec || !clk_active)
    begin
      link.recovered_bit_clock <= 1'b0;
      link.receive_data_out    <= s_slicer;
    end
    else if (sample_now)
    begin
      // Fresh bit and clock rise together, so no bit lags behind the start
      link.recovered_bit_clock <= 1'b1;
      link.receive_data_out    <= s_slicer;
    end
    else if (bit_cnt == 16'h0000)
      link.recovered_bit_clock <= 1'b0;
  end

  // Config port only works in enhanced mode with select high
  assign cfg_on = woke & s_sel;

  // Config shifter; a set top bit in the command byte asks for a read
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_bits            <= 3'h0;
      cfg_asm             <= 8'h00;
      rd_shift            <= 8'h00;
      first_byte          <= 1'b1;
      reading             <= 1'b0;
      control_byte        <= 8'h00;
      control_byte_strobe <= 1'b0;
      link.dev_data_o     <= 1'b0;
    end
    else
    begin
      control_byte_strobe <= 1'b0;
      if (!cfg_on)
      begin
        cfg_bits   <= 3'h0;
        first_byte <= 1'b1;
        reading    <= 1'b0;
      end
      else if (cclk_rise)
      begin
        cfg_bits <= cfg_bits + 3'h1;
        if (reading)
        begin
          link.dev_data_o <= rd_shift[7];
          rd_shift        <= {rd_shift[6:0], 1'b0};
          first_byte      <= 1'b0;
        end
        else
        begin
          cfg_asm <= {cfg_asm[6:0], s_cdat};
          if (cfg_bits == 3'h7)
          begin
            if (first_byte && cfg_asm[`CFG_READ_BIT - 1])
            begin
              // Read returns the control register as it stood
              reading  <= 1'b1;
              rd_shift <= control_byte;
            end
            else
            begin
              first_byte          <= 1'b0;
              control_byte        <= {cfg_asm[6:0], s_cdat};
              control_byte_strobe <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Driving only in a selected enhanced read; never in legacy
  // Drive starts at the first read-back rise, after the host has let go
  assign link.dev_data_oe = cfg_on & reading & ~first_byte;

endmodule : radio_device

/* File: logic/radio_host.sv */
`timescale 1ns/1ps
`include "radio_regs.svh"
module radio_host (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Power-up and mode requests
  input  wire logic       powerup_mode_jumper,
  input  wire logic       tx_rx_in,
  input  wire logic       keying_in,
  input  wire logic       sleep_in,
  input  wire logic       rate_slow_in,
  input  wire logic       start_pattern_on,
  input  wire logic       rearm,
  input  wire logic [1:0] legacy_bits,
  // Config requests
  input  wire logic       cfg_req,
  input  wire logic       cfg_read,
  input  wire logic [7:0] cfg_wdata,
  output logic            cfg_busy,
  output logic [7:0]      cfg_rdata,
  output logic            cfg_rdata_valid,
  // Received bits
  output logic            rx_bit,
  output logic            rx_bit_valid,
  // Link to the device
  radio_link_if.host      link
);
  import radio_pkg::*;

  localparam logic [7:0] HALF  = 8'(`CFG_HALF_CYCLES);
  localparam logic [7:0] REARM = 8'(`REARM_LOW_CYCLES);

  cfg_state_t  state;       // Config sequencer
  logic        strap_taken; // Strap captured
  logic        enh;         // Enhanced mode chosen at power-up
  logic [7:0]  tick;        // Half-period timer
  logic [7:0]  rearm_cnt;   // Start enable low time left
  logic [4:0]  idx;         // Bit index in the transfer
  logic [4:0]  last_idx;    // Final bit index
  logic [7:0]  tx_byte;     // Command byte being sent
  logic        cclk;        // Generated config clock
  logic [2:0]  rbc_s;       // Recovered clock sync and history
  logic [1:0]  rxd_s;       // Receive data sync
  logic [1:0]  dat_s;       // Config data sync

  // Strap is captured by a clocked process after reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_taken <= 1'b0;
      enh         <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      enh         <= powerup_mode_jumper;
    end
  end

  // Mode pins; unused pins are tied low from reset on
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      link.tx_rx_select        <= 1'b0;
      link.keying_select       <= 1'b0;
      link.sleep_select        <= 1'b0;
      link.receive_rate_select <= 1'b1;
      link.enhanced_mode_wake  <= 1'b0;
    end
    else
    begin
      link.tx_rx_select        <= tx_rx_in;
      link.keying_select       <= keying_in;
      link.sleep_select        <= sleep_in;
      link.receive_rate_select <= rate_slow_in;
      link.enhanced_mode_wake  <= strap_taken & enh;
    end
  end

  assign link.unused_a = 1'b0;
  assign link.unused_b = 1'b0;

  // Re-arm holds start enable low for a while, then restores it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rearm_cnt                 <= 8'h00;
      link.start_pattern_enable <= 1'b0;
    end
    else
    begin
      if (rearm)
        rearm_cnt <= REARM;
      else if (rearm_cnt != 8'h00)
        rearm_cnt <= rearm_cnt - 8'h01;
      link.start_pattern_enable <= start_pattern_on & ~rearm & (rearm_cnt == 8'h00);
    end
  end

  // Synchronisers for device outputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rbc_s <= 3'h0;
      rxd_s <= 2'h0;
      dat_s <= 2'h0;
    end
    else
    begin
      rbc_s <= {rbc_s[1:0], link.recovered_bit_clock};
      rxd_s <= {rxd_s[0], link.receive_data_out};
      dat_s <= {dat_s[0], link.config_serial_data};
    end
  end

  // Take each received bit at the falling recovered clock edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_bit       <= 1'b0;
      rx_bit_valid <= 1'b0;
    end
    else
    begin
      rx_bit_valid <= rbc_s[2] & ~rbc_s[1];
      if (rbc_s[2] & ~rbc_s[1])
        rx_bit <= rxd_s[1];
    end
  end

  // Config sequencer: data set while clock low, sampled before fall
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state           <= CFG_IDLE;
      tick            <= 8'h00;
      idx             <= 5'h00;
      last_idx        <= 5'h07;
      tx_byte         <= 8'h00;
      cclk            <= 1'b0;
      cfg_rdata       <= 8'h00;
      cfg_rdata_valid <= 1'b0;
    end
    else
    begin
      cfg_rdata_valid <= 1'b0;
      unique case (state)
        CFG_IDLE:
        begin
          if (cfg_req && enh)
          begin
            tx_byte  <= {cfg_read, cfg_wdata[6:0]};
            last_idx <= cfg_read ? 5'h0F : 5'h07;
            idx      <= 5'h00;
            tick     <= HALF;
            state    <= CFG_LOW;
          end
        end
        CFG_LOW:
        begin
          tick <= tick - 8'h01;
          if (tick == 8'h01)
          begin
            cclk  <= 1'b1;
            tick  <= HALF;
            state <= CFG_HIGH;
          end
        end
        CFG_HIGH:
        begin
          tick <= tick - 8'h01;
          if (tick == 8'h01)
          begin
            cclk <= 1'b0;
            if (idx >= 5'h08)
              cfg_rdata <= {cfg_rdata[6:0], dat_s[1]};
            if (idx < 5'h08)
              tx_byte <= {tx_byte[6:0], 1'b0};
            tick <= HALF;
            if (idx == last_idx)
              state <= CFG_END;
            else
            begin
              idx   <= idx + 5'h01;
              state <= CFG_LOW;
            end
          end
        end
        CFG_END:
        begin
          tick <= tick - 8'h01;
          if (tick == 8'h01)
          begin
            cfg_rdata_valid <= (last_idx == 5'h0F);
            state           <= CFG_IDLE;
          end
        end
      endcase
    end
  end

  assign cfg_busy                 = (state != CFG_IDLE);
  // Select frames the transfer; legacy drives the mode bits instead
  assign link.config_select       = enh & (state == CFG_LOW | state == CFG_HIGH);
  assign link.config_serial_clock = enh ? cclk : legacy_bits[0];
  assign link.host_data_o         = enh ? tx_byte[7] : legacy_bits[1];
  assign link.host_data_oe        = ~enh | (cfg_busy & idx < 5'h08);

endmodule : radio_host

/* File: tb/radio_link_checker.sv */
`timescale 1ns/1ps
module radio_link_checker (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic rst,
  // Host-driven link signals
  input wire logic start_pattern_enable,
  input wire logic enhanced_mode_wake,
  input wire logic unused_a,
  input wire logic unused_b,
  input wire logic config_select,
  input wire logic config_serial_clock,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  // Device-driven link signals
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic recovered_bit_clock,
  input wire logic receive_data_out
);
  a_unused_low: assert property (@(posedge ref_clk) disable iff (rst)
    !unused_a && !unused_b) else $error("unused inputs driven");
  a_wake_held: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(enhanced_mode_wake) |=> enhanced_mode_wake[*8]) else $error("wake dropped");
  a_host_bit_stable: assert property (@(posedge ref_clk) disable iff (rst)
    config_select && host_data_oe && config_serial_clock |-> $stable(host_data_o))
    else $error("host data moved while clock high");
  // Both ends driving the data line at once would short it
  a_no_fight: assert property (@(posedge link_clk) disable iff (rst)
    config_select |-> !(dev_data_oe && host_data_oe)) else $error("data line contention");
  a_quiet_unsel: assert property (@(posedge link_clk) disable iff (rst)
    !config_select [*8] |-> !dev_data_oe) else $error("device drives while unselected");
  a_drive_on_rise: assert property (@(posedge link_clk) disable iff (rst)
    $rose(dev_data_oe) |-> config_serial_clock && config_select)
    else $error("device drive not at clock rise");
  a_dev_bit_stable: assert property (@(posedge link_clk) disable iff (rst)
    config_serial_clock && $past(config_serial_clock, 8) && $past(dev_data_oe)
    |-> $stable(dev_data_o)) else $error("device data moved late in high phase");
  a_data_on_rise: assert property (@(posedge link_clk) disable iff (rst)
    $fell(recovered_bit_clock) |-> $stable(receive_data_out))
    else $error("receive data moved at clock fall");
  a_rearm_quiet: assert property (@(posedge link_clk) disable iff (rst)
    $rose(start_pattern_enable) |-> ##8 !recovered_bit_clock[*8])
    else $error("recovered clock runs after re-arm");
endmodule : radio_link_checker

/* File: tb/tb_radio_mode_pin_control.sv */
`timescale 1ns/1ps
module tb_radio_mode_pin_control;
  import radio_pkg::*;
  logic ref_clk, link_clk, rst, jumper, rec_en, slicer, tx_rx, key_in, sleep_in, rate_in;
  logic start_pattern_enable_on, rearm, cfg_req, cfg_read, cfg_busy, rdv, rx_bit, rx_v, slow, enh, strobe;
  logic [1:0]  leg_bits;
  logic [7:0]  wdata, rdata, cbyte, d;
  op_mode_t    op_mode;
  keying_t     keying;
  int          mismatches, n_compared, cycles;
  logic [31:0] seed = 32'h18b3_5fc3;
  logic [7:0]  q_wr[$], q_rd[$];
  logic        q_rx[$];
  radio_link_if i_radio_link_if ();
  radio_device #(.SLOW_BIT_CYCLES(100), .FAST_BIT_CYCLES(25)) i_radio_device (
    .link_clk(link_clk), .rst(rst), .powerup_mode_jumper(jumper), .recovery_enable(rec_en),
    .slicer_data(slicer), .op_mode(op_mode), .keying(keying), .slow_rate(slow),
    .enhanced_active(enh), .control_byte(cbyte), .control_byte_strobe(strobe),
    .link(i_radio_link_if.device));
  radio_host i_radio_host (
    .ref_clk(ref_clk), .rst(rst), .powerup_mode_jumper(jumper), .tx_rx_in(tx_rx),
    .keying_in(key_in), .sleep_in(sleep_in), .rate_slow_in(rate_in), .start_pattern_on(start_pattern_enable_on),
    .rearm(rearm), .legacy_bits(leg_bits), .cfg_req(cfg_req), .cfg_read(cfg_read),
    .cfg_wdata(wdata), .cfg_busy(cfg_busy), .cfg_rdata(rdata), .cfg_rdata_valid(rdv),
    .rx_bit(rx_bit), .rx_bit_valid(rx_v), .link(i_radio_link_if.host));
  radio_link_checker i_radio_link_checker (
    .ref_clk(ref_clk), .link_clk(link_clk), .rst(rst),
    .start_pattern_enable(i_radio_link_if.start_pattern_enable),
    .enhanced_mode_wake(i_radio_link_if.enhanced_mode_wake),
    .unused_a(i_radio_link_if.unused_a), .unused_b(i_radio_link_if.unused_b),
    .config_select(i_radio_link_if.config_select),
    .config_serial_clock(i_radio_link_if.config_serial_clock),
    .host_data_o(i_radio_link_if.host_data_o), .host_data_oe(i_radio_link_if.host_data_oe),
    .dev_data_o(i_radio_link_if.dev_data_o), .dev_data_oe(i_radio_link_if.dev_data_oe),
    .recovered_bit_clock(i_radio_link_if.recovered_bit_clock),
    .receive_data_out(i_radio_link_if.receive_data_out));
  // Reference clock, 100 ns
  initial
  begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Link clock, 32 ns, offset so edges never line up with the reference
  initial
  begin
    link_clk = 0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      test_done();
    end
  end
  // Result watchers take the oldest note when a result shows
  always @(posedge ref_clk)
  begin
    if (rdv && q_rd.size() > 0) check(rdata, q_rd.pop_front(), "read back");
    if (rx_v && q_rx.size() > 0) check(rx_bit, q_rx.pop_front(), "rx bit");
  end
  always @(posedge link_clk)
    if (strobe && q_wr.size() > 0) check(cbyte, q_wr.pop_front(), "control byte");
  task automatic do_reset(input logic j);
    @(negedge ref_clk);
    rst = 1;
    jumper = j;
    repeat (16) @(negedge ref_clk);
    rst = 0;
    repeat (10) @(negedge ref_clk);
  endtask : do_reset
  // One config transfer; the global guard bounds the busy wait
  task automatic cfg(input logic rd, input logic [7:0] v);
    @(negedge ref_clk);
    cfg_req = 1;
    cfg_read = rd;
    wdata = v;
    @(negedge ref_clk);
    cfg_req = 0;
    repeat (2) @(negedge ref_clk);
    while (cfg_busy) @(negedge ref_clk);
    repeat (20) @(negedge ref_clk);
  endtask : cfg
  task automatic mode(input logic t, input logic k, input logic s, input logic r);
    @(negedge ref_clk);
    {tx_rx, key_in, sleep_in, rate_in} = {t, k, s, r};
    repeat (10) @(negedge ref_clk);
    check(op_mode, s ? MODE_SLEEP : (t ? MODE_TX : MODE_RX), "mode");
    check(keying, k ? KEY_OOK : KEY_ASK, "keying");
    check(slow, r, "rate");
  endtask : mode
  // Serial slicer bits, first sent is MSB, 8 reference cycles a bit
  task automatic send(input logic [15:0] v, input int n, input logic keep);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge ref_clk);
      slicer = v[i];
      if (keep) q_rx.push_back(v[i]);
      repeat (7) @(negedge ref_clk);
    end
  endtask : send
  initial
  begin
    {tx_rx, key_in, sleep_in, rate_in, start_pattern_enable_on, rearm, cfg_req, cfg_read} = '0;
    {leg_bits, wdata, slicer, rec_en, jumper} = '0;
    rst = 1;
    do_reset(1);
    check(enh, 1, "awake");
    for (int i = 0; i < 16; i++) mode(i[3], i[2], i[1], i[0]);
    mode(0, 0, 0, 0);
    for (int i = 0; i < 2; i++)
    begin
      d = xs() & 8'h7f;
      q_wr.push_back(d);
      cfg(0, d);
      q_rd.push_back(d);
      cfg(1, xs());
    end
    check(i_radio_link_if.recovered_bit_clock, 0, "clock idle");
    rec_en = 1;
    start_pattern_enable_on = 1;
    send(16'h0000, 8, 0);
    send(16'hE2E2, 16, 0);
    send({8'h00, xs()}, 8, 1);
    send(16'h0000, 4, 0);
    rearm = 1;
    @(negedge ref_clk);
    rearm = 0;
    repeat (40) @(negedge ref_clk);
    check(i_radio_link_if.recovered_bit_clock, 0, "clock re-armed");
    // Without pattern enable the plain start symbol starts the clock
    start_pattern_enable_on = 0;
    send(16'h00E2, 16, 0);
    send({8'h00, xs()}, 8, 1);
    send(16'h0000, 4, 0);
    do_reset(0);
    check(enh, 0, "legacy asleep");
    for (int b = 0; b < 4; b++)
    begin
      @(negedge ref_clk);
      leg_bits = b[1:0];
      repeat (10) @(negedge ref_clk);
      check(op_mode, b == 0 ? MODE_SLEEP : (b == 3 ? MODE_RX : MODE_TX), "legacy");
      if (b == 1 || b == 2) check(keying, b == 1 ? KEY_OOK : KEY_ASK, "legacy key");
    end
    cfg_req = 1;
    @(negedge ref_clk);
    cfg_req = 0;
    @(negedge ref_clk);
    check(cfg_busy, 0, "legacy config");
    check(q_wr.size() + q_rd.size() + q_rx.size(), 0, "pending");
    test_done();
  end
endmodule : tb_radio_mode_pin_control
